/* design/nvirq_ctrl.sv */
// Interrupt controller: arbitration, stacking, vectoring, tail chain and sleep
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Thirty-two request lines, four priority levels each
// - Non-maskable input that masking cannot disable
// - Each line level or pulse sensitive
// - Priorities programmable and changeable at run time
// - Preempt only on strictly higher priority
// - Handler address fetched from vector table
// - Stack eight core registers before vector fetch
// - Restore stacked registers when handler ends
// - Tail chain pending handler without unstacking
// - Late arrival retargets vector without restacking
// - Handlers run in handler mode
// - Wake detector wakes core on enabled request
// - Sleep on wait instructions or sleep-on-exit
// - Abandon multi-cycle instruction on interrupt entry
module nvirq_ctrl (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [31:0] irq_in,
  input wire logic [31:0] irq_en,
  input wire logic [31:0] irq_pulse_mode,
  input wire logic [63:0] irq_prio,
  input wire logic nmi_in,
  input wire logic [31:0] vtor_base,
  output logic [2:0] core_reg_sel,
  input wire logic [31:0] core_reg_rdata,
  output logic core_abandon,
  output logic vec_req,
  output logic [31:0] vec_addr,
  input wire logic vec_ack,
  input wire logic [31:0] vec_data,
  output logic handler_go,
  output logic [31:0] handler_pc,
  output logic handler_mode,
  output logic [5:0] active_exc,
  input wire logic exc_return,
  output logic rest_valid,
  output logic [2:0] rest_sel,
  output logic [31:0] rest_data,
  input wire logic wait_for_irq_instr,
  input wire logic wait_for_event_instr,
  input wire logic event_in,
  input wire logic sleep_on_exit,
  output logic sleep_out,
  output logic wake_out
);

  function automatic logic [7:0] pick_best(input logic [31:0] req, input logic [63:0] prio);
    logic [2:0] lvl;
    logic [4:0] num;
    logic [2:0] cand;
    lvl = nvirq_pkg::LVL_NONE;
    num = 5'h00;
    cand = nvirq_pkg::LVL_NONE;
    for (int i = 31; i >= 0; i--) begin
      cand = {1'b0, prio[2*i +: 2]} + nvirq_pkg::LVL_IRQ_OFS;
      if (req[i] && cand <= lvl) begin
        lvl = cand;
        num = 5'(i);
      end
    end
    return {lvl, num};
  endfunction

  function automatic logic [2:0] lowest_set(input logic [4:0] m);
    logic [2:0] lvl;
    lvl = nvirq_pkg::LVL_NONE;
    for (int i = 4; i >= 0; i--) begin
      if (m[i]) begin
        lvl = 3'(i);
      end
    end
    return lvl;
  endfunction

  function automatic logic [5:0] exc_of(input logic nmi, input logic [4:0] num);
    return nmi ? nvirq_pkg::EXC_NMI : nvirq_pkg::EXC_IRQ_BASE + {1'b0, num};
  endfunction

  nvirq_pkg::nvirq_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] depth_q, depth_d;
  logic [4:0] act_q, act_d;
  logic [5:0] lexc_q [0:4];
  logic [5:0] lexc_d [0:4];
  logic [2:0] tgt_lvl_q, tgt_lvl_d;
  logic [4:0] tgt_num_q, tgt_num_d;
  logic tgt_nmi_q, tgt_nmi_d;
  logic abandon_q, abandon_d;
  logic vec_req_q, vec_req_d;
  logic [31:0] vec_addr_q, vec_addr_d;
  logic go_q, go_d;
  logic [31:0] pc_q, pc_d;
  logic hmode_q, hmode_d;
  logic [5:0] aexc_q, aexc_d;
  logic rest_valid_q, rest_valid_d;
  logic [2:0] rest_sel_q, rest_sel_d;
  logic wake_q, wake_d;
  logic wfe_sl_q, wfe_sl_d;
  logic [31:0] pend_q, pend_d, prev_q, irq_set, clr_irq;
  logic nmi_pend_q, nmi_pend_d, nmi_prev_q, clr_nmi;
  logic evt_q, evt_d, evt_use;
  logic [7:0] irq_best;
  logic [2:0] best_lvl, cur_lvl, pop_lvl, new_lvl, nt_lvl;
  logic [4:0] best_num, pop_mask, nt_num;
  logic best_nmi, nt_nmi, preempt, chain_ok, late, wake_any;
  logic [31:0] nt_addr;
  logic [2:0] depth_m1;

  // Arbitration; masking never touches the non-maskable source
  always_comb begin
    irq_best = pick_best(pend_q & irq_en, irq_prio);
    best_nmi = nmi_pend_q;
    best_lvl = nmi_pend_q ? nvirq_pkg::LVL_NMI : irq_best[7:5];
    best_num = irq_best[4:0];
    cur_lvl = lowest_set(act_q);
    pop_mask = act_q & ~(5'h01 << cur_lvl);
    pop_lvl = lowest_set(pop_mask);
    preempt = best_lvl < cur_lvl;
    chain_ok = best_lvl < pop_lvl;
    late = (st_q == nvirq_pkg::ST_STACK || st_q == nvirq_pkg::ST_VEC) && best_lvl < tgt_lvl_q;
    nt_lvl = (st_q == nvirq_pkg::ST_RUN || late) ? best_lvl : tgt_lvl_q;
    nt_num = (st_q == nvirq_pkg::ST_RUN || late) ? best_num : tgt_num_q;
    nt_nmi = (st_q == nvirq_pkg::ST_RUN || late) ? best_nmi : tgt_nmi_q;
    nt_addr = vtor_base + {24'h000000, exc_of(nt_nmi, nt_num), 2'b00};
    depth_m1 = depth_q - 3'h1;
    wake_any = (|(irq_in & irq_en)) | (|(pend_q & irq_en)) | nmi_pend_q | nmi_in
      | (wfe_sl_q & evt_q);
  end

  nvirq_frame_mem u_frame (
    .clk(ref_clk),
    .rstn(rstn),
    .en(clk_en),
    .we(st_q == nvirq_pkg::ST_STACK),
    .waddr({depth_q, cnt_q[2:0]}),
    .wdata(core_reg_rdata),
    .raddr({depth_m1, cnt_q[2:0]}),
    .rdata(rest_data)
  );

  // Sequencer next state
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    depth_d = depth_q;
    act_d = act_q;
    lexc_d = lexc_q;
    tgt_lvl_d = nt_lvl;
    tgt_num_d = nt_num;
    tgt_nmi_d = nt_nmi;
    abandon_d = 1'b0;
    vec_req_d = vec_req_q;
    vec_addr_d = vec_addr_q;
    go_d = 1'b0;
    pc_d = pc_q;
    rest_valid_d = 1'b0;
    rest_sel_d = rest_sel_q;
    wake_d = 1'b0;
    wfe_sl_d = wfe_sl_q;
    clr_irq = 32'h00000000;
    clr_nmi = 1'b0;
    evt_use = 1'b0;
    new_lvl = nvirq_pkg::LVL_NONE;
    case (st_q)
      nvirq_pkg::ST_RUN: begin
        if (exc_return && depth_q != nvirq_pkg::RST_DEPTH) begin
          act_d = pop_mask;
          if (chain_ok) begin
            st_d = nvirq_pkg::ST_VEC;
            vec_req_d = 1'b1;
            vec_addr_d = nt_addr;
          end else begin
            st_d = nvirq_pkg::ST_UNSTACK;
            cnt_d = 4'h0;
          end
        end else if (preempt) begin
          st_d = nvirq_pkg::ST_STACK;
          cnt_d = 4'h0;
          abandon_d = 1'b1;
        end else if (wait_for_irq_instr) begin
          st_d = nvirq_pkg::ST_SLEEP;
          wfe_sl_d = 1'b0;
        end else if (wait_for_event_instr) begin
          if (evt_q) begin
            evt_use = 1'b1;
          end else begin
            st_d = nvirq_pkg::ST_SLEEP;
            wfe_sl_d = 1'b1;
          end
        end
      end
      nvirq_pkg::ST_STACK: begin
        if (cnt_q == nvirq_pkg::FRAME_LAST) begin
          st_d = nvirq_pkg::ST_VEC;
          cnt_d = 4'h0;
          depth_d = depth_q + 3'h1;
          vec_req_d = 1'b1;
          vec_addr_d = nt_addr;
        end else begin
          cnt_d = cnt_q + 4'h1;
        end
      end
      nvirq_pkg::ST_VEC: begin
        if (late) begin
          vec_addr_d = nt_addr;
        end else if (vec_ack) begin
          st_d = nvirq_pkg::ST_RUN;
          vec_req_d = 1'b0;
          go_d = 1'b1;
          pc_d = vec_data;
          act_d = act_q | (5'h01 << tgt_lvl_q);
          lexc_d[tgt_lvl_q] = exc_of(tgt_nmi_q, tgt_num_q);
          clr_irq = tgt_nmi_q ? 32'h00000000 : (32'h00000001 << tgt_num_q);
          clr_nmi = tgt_nmi_q;
        end
      end
      nvirq_pkg::ST_UNSTACK: begin
        rest_valid_d = 1'b1;
        rest_sel_d = cnt_q[2:0];
        if (cnt_q == nvirq_pkg::FRAME_LAST) begin
          depth_d = depth_m1;
          cnt_d = 4'h0;
          wfe_sl_d = 1'b0;
          st_d = (sleep_on_exit && depth_m1 == nvirq_pkg::RST_DEPTH) ?
            nvirq_pkg::ST_SLEEP : nvirq_pkg::ST_RUN;
        end else begin
          cnt_d = cnt_q + 4'h1;
        end
      end
      nvirq_pkg::ST_SLEEP: begin
        if (wake_any) begin
          st_d = nvirq_pkg::ST_RUN;
          wake_d = 1'b1;
          evt_use = wfe_sl_q;
        end
      end
      default: begin
        st_d = nvirq_pkg::ST_RUN;
      end
    endcase
    new_lvl = lowest_set(act_d);
    hmode_d = (|act_d) | (st_d == nvirq_pkg::ST_VEC);
    aexc_d = (new_lvl == nvirq_pkg::LVL_NONE) ? nvirq_pkg::EXC_THREAD : lexc_d[new_lvl];
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= nvirq_pkg::ST_RUN;
      cnt_q <= 4'h0;
      depth_q <= nvirq_pkg::RST_DEPTH;
      act_q <= nvirq_pkg::RST_ACTIVE;
      for (int i = 0; i < 5; i++) begin
        lexc_q[i] <= nvirq_pkg::EXC_THREAD;
      end
      tgt_lvl_q <= nvirq_pkg::LVL_NONE;
      tgt_num_q <= 5'h00;
      tgt_nmi_q <= 1'b0;
      abandon_q <= 1'b0;
      vec_req_q <= 1'b0;
      vec_addr_q <= nvirq_pkg::RST_WORD;
      go_q <= 1'b0;
      pc_q <= nvirq_pkg::RST_WORD;
      hmode_q <= 1'b0;
      aexc_q <= nvirq_pkg::EXC_THREAD;
      rest_valid_q <= 1'b0;
      rest_sel_q <= nvirq_pkg::SEL_R0;
      wake_q <= 1'b0;
      wfe_sl_q <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      depth_q <= depth_d;
      act_q <= act_d;
      lexc_q <= lexc_d;
      tgt_lvl_q <= tgt_lvl_d;
      tgt_num_q <= tgt_num_d;
      tgt_nmi_q <= tgt_nmi_d;
      abandon_q <= abandon_d;
      vec_req_q <= vec_req_d;
      vec_addr_q <= vec_addr_d;
      go_q <= go_d;
      pc_q <= pc_d;
      hmode_q <= hmode_d;
      aexc_q <= aexc_d;
      rest_valid_q <= rest_valid_d;
      rest_sel_q <= rest_sel_d;
      wake_q <= wake_d;
      wfe_sl_q <= wfe_sl_d;
    end
  end

  // Pending capture; a new event beats a clear in the same cycle
  always_comb begin
    irq_set = (irq_in & ~irq_pulse_mode) | (irq_in & ~prev_q & irq_pulse_mode);
    pend_d = (pend_q & ~clr_irq) | irq_set;
    nmi_pend_d = (nmi_pend_q & ~clr_nmi) | (nmi_in & ~nmi_prev_q);
    evt_d = (evt_q & ~evt_use) | event_in;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= 32'h00000000;
      prev_q <= 32'h00000000;
      nmi_pend_q <= 1'b0;
      nmi_prev_q <= 1'b0;
      evt_q <= 1'b0;
    end else if (clk_en) begin
      pend_q <= pend_d;
      prev_q <= irq_in;
      nmi_pend_q <= nmi_pend_d;
      nmi_prev_q <= nmi_in;
      evt_q <= evt_d;
    end
  end

  assign core_reg_sel = cnt_q[2:0];
  assign core_abandon = abandon_q;
  assign vec_req = vec_req_q;
  assign vec_addr = vec_addr_q;
  assign handler_go = go_q;
  assign handler_pc = pc_q;
  assign handler_mode = hmode_q;
  assign active_exc = aexc_q;
  assign rest_valid = rest_valid_q;
  assign rest_sel = rest_sel_q;
  assign sleep_out = (st_q == nvirq_pkg::ST_SLEEP);
  assign wake_out = wake_q;

  chk_irq_level_pend: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (!irq_pulse_mode[5] && irq_in[5]) |=> pend_q[5])
    else $error("level request not pending");
  chk_nmi_unmasked: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (st_q == nvirq_pkg::ST_RUN && nmi_pend_q && !act_q[0] && !exc_return) |=>
    (st_q == nvirq_pkg::ST_STACK && tgt_nmi_q))
    else $error("non-maskable request not taken");
  chk_pulse_capture: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (irq_pulse_mode[0] && irq_in[0] && !prev_q[0]) |=> pend_q[0])
    else $error("pulse edge lost");
  chk_preempt_strict: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (st_q == nvirq_pkg::ST_RUN && !exc_return && best_lvl >= cur_lvl) |=>
    st_q != nvirq_pkg::ST_STACK)
    else $error("preempted without higher priority");
  chk_go_after_ack: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    handler_go |-> ($past(vec_ack) && $past(st_q) == nvirq_pkg::ST_VEC && handler_pc == $past(vec_data)))
    else $error("handler start without vector");
  chk_stack_eight: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    $rose(st_q == nvirq_pkg::ST_STACK) |-> (st_q == nvirq_pkg::ST_STACK)[*8] ##1
    (st_q == nvirq_pkg::ST_VEC && vec_req))
    else $error("stacking length wrong");
  chk_unstack_words: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    $rose(st_q == nvirq_pkg::ST_UNSTACK) |=> rest_valid[*8] ##1 !rest_valid)
    else $error("restore word count wrong");
  chk_tail_chain: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (st_q == nvirq_pkg::ST_RUN && exc_return && depth_q != 3'h0 && chain_ok) |=>
    (st_q == nvirq_pkg::ST_VEC && $stable(depth_q)))
    else $error("tail chain unstacked");
  chk_late_retarget: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (st_q == nvirq_pkg::ST_VEC && late) |=> (st_q == nvirq_pkg::ST_VEC && !handler_go))
    else $error("late arrival not retargeted");
  chk_handler_mode: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    handler_go |-> handler_mode)
    else $error("handler outside handler mode");
  chk_wake_sleep: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (sleep_out && wake_any) |=> (wake_out && !sleep_out))
    else $error("wake missed");
  chk_wfi_sleep: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (st_q == nvirq_pkg::ST_RUN && wait_for_irq_instr && !exc_return && !preempt) |=> sleep_out)
    else $error("wait for interrupt did not sleep");
  chk_abandon_entry: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    $rose(st_q == nvirq_pkg::ST_STACK) |-> core_abandon)
    else $error("no abandon on entry");
  chk_pend_kept: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
    (pend_q[3] && !(st_q == nvirq_pkg::ST_VEC && vec_ack && !late && !tgt_nmi_q
    && tgt_num_q == 5'h03)) |=> pend_q[3])
    else $error("pending request dropped");
endmodule
`default_nettype wire

/* design/nvirq_pkg.sv */
// Shared constants and types for the nested vectored interrupt controller
package nvirq_pkg;
  localparam int NUM_IRQ = 32;
  localparam int PRIO_W = 2;
  localparam int LVL_W = 3;
  localparam int EXC_W = 6;
  localparam int DEPTH_W = 3;
  localparam int MEM_AW = 6;
  localparam int MEM_WORDS = 40;
  // Urgency levels: 0 is the non-maskable source, 1..4 are priorities 0..3
  localparam logic [2:0] LVL_NMI = 3'h0;
  localparam logic [2:0] LVL_NONE = 3'h5;
  localparam logic [2:0] LVL_IRQ_OFS = 3'h1;
  // Exception numbers used to index the vector table
  localparam logic [5:0] EXC_THREAD = 6'h00;
  localparam logic [5:0] EXC_NMI = 6'h02;
  localparam logic [5:0] EXC_IRQ_BASE = 6'h10;
  // Stack frame word order, also the core register select code
  localparam logic [2:0] SEL_R0 = 3'h0;
  localparam logic [2:0] SEL_R1 = 3'h1;
  localparam logic [2:0] SEL_R2 = 3'h2;
  localparam logic [2:0] SEL_R3 = 3'h3;
  localparam logic [2:0] SEL_R12 = 3'h4;
  localparam logic [2:0] SEL_LINK = 3'h5;
  localparam logic [2:0] SEL_PC = 3'h6;
  localparam logic [2:0] SEL_STATUS = 3'h7;
  localparam logic [3:0] FRAME_LAST = 4'h7;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [2:0] RST_DEPTH = 3'h0;
  localparam logic [4:0] RST_ACTIVE = 5'h00;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_STACK = 3'b001,
    ST_VEC = 3'b010,
    ST_UNSTACK = 3'b011,
    ST_SLEEP = 3'b100
  } nvirq_state_t;
endpackage

/* design/nvirq_frame_mem.sv */
// Stack frame memory: one eight-word frame per nesting depth
`timescale 1ns/1ps
`default_nettype none
module nvirq_frame_mem (
  input wire logic clk,
  input wire logic rstn,
  input wire logic en,
  input wire logic we,
  input wire logic [5:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [5:0] raddr,
  output logic [31:0] rdata
);
  logic [31:0] mem_q [0:nvirq_pkg::MEM_WORDS-1];
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Frame storage, no reset needed
  always_ff @(posedge clk) begin
    if (en && we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_comb begin
    rdata_d = en ? mem_q[raddr] : rdata_q;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= nvirq_pkg::RST_WORD;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
endmodule
`default_nettype wire

/* test/nvirq_core_model.sv */
// Core and vector memory model facing the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module nvirq_core_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [2:0] core_reg_sel,
  output logic [31:0] core_reg_rdata,
  input wire logic vec_req,
  input wire logic [31:0] vec_addr,
  output logic vec_ack,
  output logic [31:0] vec_data,
  input wire logic [15:0] tag,
  input wire logic [3:0] ack_dly
);
  logic [3:0] cnt_q;
  // Register file value tagged with the current frame
  assign core_reg_rdata = {tag, 13'h0000, core_reg_sel};
  // Vector table word, scrambled outside the ack cycle
  assign vec_data = vec_ack ? (vec_addr + 32'h10000000) : ~(vec_addr + 32'h10000000);
  // Ack after a programmable wait, one cycle long
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
      vec_ack <= 1'b0;
    end else if (vec_ack) begin
      vec_ack <= 1'b0;
      cnt_q <= 4'h0;
    end else if (vec_req) begin
      if (cnt_q == ack_dly) begin
        vec_ack <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end else begin
      cnt_q <= 4'h0;
    end
  end
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Self-checking testbench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [31:0] BASE = 32'h00002000;
  logic ref_clk, rstn, clk_en, nmi_in, vec_ack, exc_return, sleep_on_exit;
  logic wait_for_irq_instr, wait_for_event_instr, event_in;
  logic [31:0] irq_in, irq_en, irq_pulse_mode, vtor_base, core_reg_rdata, vec_data;
  logic [63:0] irq_prio;
  logic [2:0] core_reg_sel, rest_sel;
  logic core_abandon, vec_req, handler_go, handler_mode, rest_valid, sleep_out, wake_out;
  logic [31:0] vec_addr, handler_pc, rest_data, ack_addr;
  logic [5:0] active_exc;
  logic [15:0] core_tag, exp_tag;
  logic [3:0] ack_dly;
  int failures, tests_run, n_ab, n_rest, n_wake, sk, rk;

  nvirq_ctrl i_dut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .irq_in(irq_in),
    .irq_en(irq_en), .irq_pulse_mode(irq_pulse_mode), .irq_prio(irq_prio), .nmi_in(nmi_in),
    .vtor_base(vtor_base), .core_reg_sel(core_reg_sel), .core_reg_rdata(core_reg_rdata),
    .core_abandon(core_abandon), .vec_req(vec_req), .vec_addr(vec_addr), .vec_ack(vec_ack),
    .vec_data(vec_data), .handler_go(handler_go), .handler_pc(handler_pc),
    .handler_mode(handler_mode), .active_exc(active_exc), .exc_return(exc_return),
    .rest_valid(rest_valid), .rest_sel(rest_sel), .rest_data(rest_data),
    .wait_for_irq_instr(wait_for_irq_instr), .wait_for_event_instr(wait_for_event_instr),
    .event_in(event_in), .sleep_on_exit(sleep_on_exit), .sleep_out(sleep_out),
    .wake_out(wake_out));
  nvirq_core_model i_core (.ref_clk(ref_clk), .rstn(rstn), .core_reg_sel(core_reg_sel),
    .core_reg_rdata(core_reg_rdata), .vec_req(vec_req), .vec_addr(vec_addr),
    .vec_ack(vec_ack), .vec_data(vec_data), .tag(core_tag), .ack_dly(ack_dly));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic tick();
    @(negedge ref_clk);
  endtask

  task automatic clr();
    n_ab = 0;
    n_rest = 0;
    n_wake = 0;
  endtask

  // One cycle of watching stacking, restore, fetch and wake
  task automatic mon();
    @(negedge ref_clk);
    if (core_abandon === 1'b1) begin
      n_ab++;
      sk = 0;
    end
    if (sk < 8) begin
      chk("core_reg_sel", {29'h0, core_reg_sel}, sk);
      sk++;
    end
    if (rest_valid === 1'b1) begin
      chk("rest_sel", {29'h0, rest_sel}, rk);
      chk("rest_data", rest_data, {exp_tag, 13'h0000, rk[2:0]});
      rk++;
      n_rest++;
    end
    if (vec_ack === 1'b1) begin
      ack_addr = vec_addr;
      chk("vec_req", {31'h0, vec_req}, 1);
      // Source drops its line once its vector is taken
      if (vec_addr >= BASE + 32'h40) begin
        irq_in[5'((vec_addr - BASE - 32'h40) >> 2)] = 1'b0;
      end
    end
    if (wake_out === 1'b1) begin
      n_wake++;
    end
  endtask

  // Wait for handler start, optionally pulsing line 1 at cycle pa
  task automatic go_wait(input int pa);
    for (int i = 0; i < 80; i++) begin
      if (i == pa) irq_in[1] = 1'b1;
      if (i == pa + 1) irq_in[1] = 1'b0;
      mon();
      if (handler_go === 1'b1) begin
        chk("handler_pc", handler_pc, ack_addr + 32'h10000000);
        return;
      end
    end
    chk("handler_go", 32'h0, 32'h1);
    finish_test();
  endtask

  task automatic ret(input bit chain, input logic [15:0] tg);
    clr();
    exp_tag = tg;
    rk = 0;
    exc_return = 1'b1;
    mon();
    exc_return = 1'b0;
    if (chain) begin
      go_wait(-5);
      chk("chain_rest", n_rest, 0);
      chk("chain_stack", n_ab, 0);
    end else begin
      repeat (12) mon();
      chk("rest_words", n_rest, 8);
    end
  endtask

  task automatic sc_event();
    event_in = 1'b1;
    tick();
    event_in = 1'b0;
    wait_for_event_instr = 1'b1;
    tick();
    wait_for_event_instr = 1'b0;
    repeat (2) tick();
    chk("evt_no_wake", {31'h0, wake_out}, 0);
    chk("sleep_latched_evt", {31'h0, sleep_out}, 0);
    wait_for_event_instr = 1'b1;
    tick();
    wait_for_event_instr = 1'b0;
    repeat (2) tick();
    chk("sleep_evt", {31'h0, sleep_out}, 1);
    clk_en = 1'b0;
    event_in = 1'b1;
    tick();
    event_in = 1'b0;
    repeat (2) tick();
    chk("frozen_sleep", {31'h0, sleep_out}, 1);
    clk_en = 1'b1;
    tick();
    chk("frozen_evt_lost", {31'h0, sleep_out}, 1);
    clr();
    event_in = 1'b1;
    mon();
    event_in = 1'b0;
    repeat (3) mon();
    chk("wake_evt", n_wake, 1);
    chk("awake_evt", {31'h0, sleep_out}, 0);
  endtask

  task automatic sc_entry();
    core_tag = 16'hA1A1;
    wait_for_irq_instr = 1'b1;
    tick();
    wait_for_irq_instr = 1'b0;
    repeat (2) tick();
    chk("sleep_wfi", {31'h0, sleep_out}, 1);
    irq_prio[11:10] = 2'h2;
    clr();
    irq_in[5] = 1'b1;
    go_wait(-5);
    irq_in[5] = 1'b0;
    chk("wake_irq", n_wake, 1);
    chk("abandon", n_ab, 1);
    chk("vec_addr", ack_addr, BASE + 32'h54);
    chk("active_exc", {26'h0, active_exc}, 21);
    chk("handler_mode", {31'h0, handler_mode}, 1);
  endtask

  task automatic sc_nest();
    irq_prio[7:6] = 2'h2;
    irq_prio[13:12] = 2'h2;
    irq_in[3] = 1'b1;
    irq_in[6] = 1'b1;
    clr();
    repeat (15) mon();
    chk("equal_no_preempt", n_ab, 0);
    chk("active_exc", {26'h0, active_exc}, 21);
    core_tag = 16'hB2B2;
    clr();
    nmi_in = 1'b1;
    mon();
    nmi_in = 1'b0;
    go_wait(-5);
    chk("nmi_stack", n_ab, 1);
    chk("nmi_vec", ack_addr, BASE + 32'h8);
    chk("active_exc", {26'h0, active_exc}, 2);
    irq_prio[13:12] = 2'h0;
    ret(1'b1, 16'h0000);
    irq_in[6] = 1'b0;
    chk("chain_exc", {26'h0, active_exc}, 22);
    ret(1'b0, 16'hB2B2);
    chk("resume_exc", {26'h0, active_exc}, 21);
    ret(1'b1, 16'h0000);
    irq_in[3] = 1'b0;
    chk("pend_exc", {26'h0, active_exc}, 19);
    sleep_on_exit = 1'b1;
    ret(1'b0, 16'hA1A1);
    sleep_on_exit = 1'b0;
    chk("sleep_exit", {31'h0, sleep_out}, 1);
    chk("thread_mode", {31'h0, handler_mode}, 0);
  endtask

  task automatic sc_late();
    core_tag = 16'hC3C3;
    ack_dly = 4'h6;
    irq_pulse_mode[1] = 1'b1;
    irq_prio[3:2] = 2'h0;
    clr();
    irq_in[8] = 1'b1;
    go_wait(10);
    irq_in[8] = 1'b0;
    chk("wake_late", n_wake, 1);
    chk("late_stack", n_ab, 1);
    chk("late_vec", ack_addr, BASE + 32'h44);
    chk("late_exc", {26'h0, active_exc}, 17);
    ret(1'b1, 16'h0000);
    chk("late_chain_exc", {26'h0, active_exc}, 24);
    ret(1'b0, 16'hC3C3);
    chk("thread_exc", {26'h0, active_exc}, 0);
  endtask

  initial begin
    failures = 0;
    tests_run = 0;
    sk = 8;
    rk = 0;
    clr();
    rstn = 1'b0;
    clk_en = 1'b1;
    irq_in = 32'h00000000;
    irq_en = 32'hFFFFFFFF;
    irq_pulse_mode = 32'h00000000;
    irq_prio = 64'hFFFFFFFFFFFFFFFF;
    nmi_in = 1'b0;
    vtor_base = BASE;
    exc_return = 1'b0;
    wait_for_irq_instr = 1'b0;
    wait_for_event_instr = 1'b0;
    event_in = 1'b0;
    sleep_on_exit = 1'b0;
    core_tag = 16'h0000;
    exp_tag = 16'h0000;
    ack_dly = 4'h1;
    ack_addr = 32'h00000000;
    repeat (3) tick();
    rstn = 1'b1;
    tick();
    chk("reset_mode", {31'h0, handler_mode}, 0);
    chk("reset_exc", {26'h0, active_exc}, 0);
    sc_event();
    sc_entry();
    sc_nest();
    sc_late();
    finish_test();
  end
endmodule
`default_nettype wire
